// ==== rtl/ctb_pkg.sv ====
// Constants of the conversion timing and buffer configuration block.
package ctb_pkg;
  localparam int unsigned ADDR_W          = 8;
  // Register indices; byte address is four times the index.
  localparam logic [7:0]  IDX_BUF_STATUS  = 8'h01;
  localparam logic [7:0]  IDX_OSCILLATOR_SELECT     = 8'h18;
  localparam logic [7:0]  IDX_CLK_COUNT   = 8'h19;
  localparam logic [7:0]  IDX_WORD_LAYOUT = 8'h28;
  localparam logic [7:0]  IDX_FILL_MODE   = 8'h2c;
  // Reset values.
  localparam logic        RST_OSCILLATOR_SELECT     = 1'h0;
  localparam logic [7:0]  RST_CLK_COUNT   = 8'h00;
  localparam logic [1:0]  RST_WORD_LAYOUT = 2'h0;
  localparam logic [2:0]  RST_FILL_MODE   = 3'h1;
  // Minimum conversion clock counts per oscillator.
  localparam logic [7:0]  MIN_CLK_HS      = 8'h15;
  localparam logic [7:0]  MIN_CLK_LP      = 8'h12;
  // Oscillator choice encodings.
  localparam logic        OSC_HIGH_SPEED  = 1'h0;
  localparam logic        OSC_LOW_POWER   = 1'h1;
  // Buffer fill mode codes.
  localparam logic [2:0]  FILL_STOP_BURST  = 3'h0;
  localparam logic [2:0]  FILL_START_BURST = 3'h1;
  localparam logic [2:0]  FILL_PRE_ALERT   = 3'h4;
  localparam logic [2:0]  FILL_POST_ALERT  = 3'h6;
  // Output word layouts.
  localparam logic [1:0]  FMT_ZERO_PAD    = 2'h0;
  localparam logic [1:0]  FMT_CHANNEL     = 2'h1;
  localparam logic [1:0]  FMT_CHAN_VALID  = 2'h2;
  localparam logic [1:0]  FMT_ZERO_PAD_B  = 2'h3;
  // Data buffer geometry.
  localparam int unsigned BUF_DEPTH       = 16;
  localparam logic [4:0]  BUF_FULL_COUNT  = 5'h10;
  localparam logic [4:0]  RST_COUNT       = 5'h00;
  // AXI responses.
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
endpackage

// ==== rtl/ctb_top.sv ====
// Conversion timing and data buffer configuration registers with AXI4-Lite access.
`timescale 1ns/10ps
module ctb_top (
  input  wire logic        core_clk_in,
  input  wire logic        rstn_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        sample_strobe_in,
  input  wire logic [11:0] sample_result_in,
  input  wire logic        sample_channel_in,
  input  wire logic        sample_word_valid_in,
  output logic             sample_ready_out,
  input  wire logic        buffer_pop_in,
  input  wire logic        buffer_clear_in,
  output logic [15:0]      buffer_word_out,
  output logic             buffer_word_valid_out,
  output logic [4:0]       buffer_entry_count_out,
  output logic             oscillator_choice_bit_out,
  output logic [7:0]       conversion_clock_count_out,
  output logic [2:0]       buffer_fill_mode_out,
  output logic [1:0]       output_word_layout_out
);

  //////////////////////////////////////////////////////////////////////////////
  // Configuration and bus state.

  logic        osc_ff,        nxt_osc;
  logic [7:0]  clk_count_ff,  nxt_clk_count;
  logic [1:0]  layout_ff,     nxt_layout;
  logic [2:0]  fill_mode_ff,  nxt_fill_mode;
  logic        aw_held_ff,    nxt_aw_held;
  logic [7:0]  aw_addr_ff,    nxt_aw_addr;
  logic        w_held_ff,     nxt_w_held;
  logic [31:0] w_data_ff,     nxt_w_data;
  logic [3:0]  w_strb_ff,     nxt_w_strb;
  logic        bvalid_ff,     nxt_bvalid;
  logic [1:0]  bresp_ff,      nxt_bresp;
  logic        rvalid_ff,     nxt_rvalid;
  logic [31:0] rdata_ff,      nxt_rdata;
  logic [1:0]  rresp_ff,      nxt_rresp;
  logic [7:0]  eff_clk_ff,    nxt_eff_clk;
  logic [7:0]  wr_index;
  logic [7:0]  rd_index;

  //////////////////////////////////////////////////////////////////////////////
  // Data buffer state.

  logic [15:0] buf_mem [ctb_pkg::BUF_DEPTH];
  logic [3:0]  wr_ptr_ff,     nxt_wr_ptr;
  logic [3:0]  rd_ptr_ff,     nxt_rd_ptr;
  logic [4:0]  count_ff,      nxt_count;
  logic [15:0] head_ff,       nxt_head;
  logic        head_vld_ff,   nxt_head_vld;
  logic [15:0] packed_word;
  logic        push;
  logic        pop;

  //////////////////////////////////////////////////////////////////////////////
  // Output word layout.

  always_comb begin
    case (layout_ff)
      ctb_pkg::FMT_CHANNEL: begin
        packed_word = {sample_result_in, 2'h0, sample_channel_in, 1'h0};
      end
      ctb_pkg::FMT_CHAN_VALID: begin
        packed_word = {sample_result_in, 2'h0, sample_channel_in,
                       sample_word_valid_in};
      end
      ctb_pkg::FMT_ZERO_PAD_B: begin
        packed_word = {sample_result_in, 4'h0};
      end
      default: begin
        packed_word = {sample_result_in, 4'h0};
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register bus next state. Writes take effect only once both address and
  // data are held, so either channel may arrive first without a partial write.

  always_comb begin
    nxt_osc       = osc_ff;
    nxt_clk_count = clk_count_ff;
    nxt_layout    = layout_ff;
    nxt_fill_mode = fill_mode_ff;
    nxt_aw_held   = aw_held_ff;
    nxt_aw_addr   = aw_addr_ff;
    nxt_w_held    = w_held_ff;
    nxt_w_data    = w_data_ff;
    nxt_w_strb    = w_strb_ff;
    nxt_bvalid    = bvalid_ff;
    nxt_bresp     = bresp_ff;
    nxt_rvalid    = rvalid_ff;
    nxt_rdata     = rdata_ff;
    nxt_rresp     = rresp_ff;
    wr_index      = {2'h0, aw_addr_ff[7:2]};
    rd_index      = {2'h0, s_axi_araddr_in[7:2]};
    if (s_axi_awvalid_in && s_axi_awready_out) begin
      nxt_aw_held = 1'b1;
      nxt_aw_addr = s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in && s_axi_wready_out) begin
      nxt_w_held = 1'b1;
      nxt_w_data = s_axi_wdata_in;
      nxt_w_strb = s_axi_wstrb_in;
    end
    if (aw_held_ff && w_held_ff && !bvalid_ff) begin
      nxt_aw_held = 1'b0;
      nxt_w_held  = 1'b0;
      nxt_bvalid  = 1'b1;
      nxt_bresp   = ctb_pkg::RESP_OKAY;
      case (wr_index)
        ctb_pkg::IDX_OSCILLATOR_SELECT: begin
          if (w_strb_ff[0]) begin
            nxt_osc = w_data_ff[0];
          end
        end
        ctb_pkg::IDX_CLK_COUNT: begin
          if (w_strb_ff[0]) begin
            nxt_clk_count = w_data_ff[7:0];
          end
        end
        ctb_pkg::IDX_WORD_LAYOUT: begin
          if (w_strb_ff[0]) begin
            nxt_layout = w_data_ff[1:0];
          end
        end
        ctb_pkg::IDX_FILL_MODE: begin
          // Reserved codes are stored as written; software must avoid them.
          if (w_strb_ff[0]) begin
            nxt_fill_mode = w_data_ff[2:0];
          end
        end
        ctb_pkg::IDX_BUF_STATUS: begin
          nxt_bresp = ctb_pkg::RESP_OKAY;
        end
        default: begin
          nxt_bresp = ctb_pkg::RESP_SLVERR;
        end
      endcase
    end
    if (bvalid_ff && s_axi_bready_in) begin
      nxt_bvalid = 1'b0;
    end
    if (rvalid_ff && s_axi_rready_in) begin
      nxt_rvalid = 1'b0;
    end
    if (s_axi_arvalid_in && s_axi_arready_out) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = ctb_pkg::RESP_OKAY;
      nxt_rdata  = 32'h0;
      case (rd_index)
        ctb_pkg::IDX_OSCILLATOR_SELECT: begin
          nxt_rdata = {31'h0, osc_ff};
        end
        ctb_pkg::IDX_CLK_COUNT: begin
          nxt_rdata = {24'h0, eff_clk_ff};
        end
        ctb_pkg::IDX_WORD_LAYOUT: begin
          nxt_rdata = {30'h0, layout_ff};
        end
        ctb_pkg::IDX_FILL_MODE: begin
          nxt_rdata = {29'h0, fill_mode_ff};
        end
        ctb_pkg::IDX_BUF_STATUS: begin
          nxt_rdata = {27'h0, count_ff};
        end
        default: begin
          nxt_rresp = ctb_pkg::RESP_SLVERR;
        end
      endcase
    end
    // The clamp works on the next values, so the registered count never lags the oscillator.
    nxt_eff_clk = nxt_clk_count;
    if (nxt_osc == ctb_pkg::OSC_HIGH_SPEED) begin
      if (nxt_clk_count <= ctb_pkg::MIN_CLK_HS) begin
        nxt_eff_clk = ctb_pkg::MIN_CLK_HS;
      end
    end else if (nxt_clk_count <= ctb_pkg::MIN_CLK_LP) begin
      nxt_eff_clk = ctb_pkg::MIN_CLK_LP;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      osc_ff       <= ctb_pkg::RST_OSCILLATOR_SELECT;
      clk_count_ff <= ctb_pkg::RST_CLK_COUNT;
      eff_clk_ff   <= ctb_pkg::MIN_CLK_HS;
      layout_ff    <= ctb_pkg::RST_WORD_LAYOUT;
      fill_mode_ff <= ctb_pkg::RST_FILL_MODE;
      aw_held_ff   <= 1'b0;
      aw_addr_ff   <= 8'h0;
      w_held_ff    <= 1'b0;
      w_data_ff    <= 32'h0;
      w_strb_ff    <= 4'h0;
      bvalid_ff    <= 1'b0;
      bresp_ff     <= ctb_pkg::RESP_OKAY;
      rvalid_ff    <= 1'b0;
      rdata_ff     <= 32'h0;
      rresp_ff     <= ctb_pkg::RESP_OKAY;
    end else begin
      osc_ff       <= nxt_osc;
      clk_count_ff <= nxt_clk_count;
      eff_clk_ff   <= nxt_eff_clk;
      layout_ff    <= nxt_layout;
      fill_mode_ff <= nxt_fill_mode;
      aw_held_ff   <= nxt_aw_held;
      aw_addr_ff   <= nxt_aw_addr;
      w_held_ff    <= nxt_w_held;
      w_data_ff    <= nxt_w_data;
      w_strb_ff    <= nxt_w_strb;
      bvalid_ff    <= nxt_bvalid;
      bresp_ff     <= nxt_bresp;
      rvalid_ff    <= nxt_rvalid;
      rdata_ff     <= nxt_rdata;
      rresp_ff     <= nxt_rresp;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Data buffer. A full buffer refuses new words through sample_ready_out.

  always_comb begin
    push         = sample_strobe_in && (count_ff != ctb_pkg::BUF_FULL_COUNT);
    pop          = buffer_pop_in && (count_ff != ctb_pkg::RST_COUNT);
    nxt_wr_ptr   = wr_ptr_ff;
    nxt_rd_ptr   = rd_ptr_ff;
    nxt_count    = count_ff;
    nxt_head     = head_ff;
    nxt_head_vld = 1'b0;
    if (buffer_clear_in) begin
      nxt_wr_ptr = 4'h0;
      nxt_rd_ptr = 4'h0;
      nxt_count  = ctb_pkg::RST_COUNT;
    end else begin
      if (push) begin
        nxt_wr_ptr = wr_ptr_ff + 4'h1;
      end
      if (pop) begin
        nxt_rd_ptr   = rd_ptr_ff + 4'h1;
        nxt_head     = buf_mem[rd_ptr_ff];
        nxt_head_vld = 1'b1;
      end
      if (push && !pop) begin
        nxt_count = count_ff + 5'h1;
      end else if (pop && !push) begin
        nxt_count = count_ff - 5'h1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (push && !buffer_clear_in) begin
      buf_mem[wr_ptr_ff] <= packed_word;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      wr_ptr_ff   <= 4'h0;
      rd_ptr_ff   <= 4'h0;
      count_ff    <= ctb_pkg::RST_COUNT;
      head_ff     <= 16'h0;
      head_vld_ff <= 1'b0;
    end else begin
      wr_ptr_ff   <= nxt_wr_ptr;
      rd_ptr_ff   <= nxt_rd_ptr;
      count_ff    <= nxt_count;
      head_ff     <= nxt_head;
      head_vld_ff <= nxt_head_vld;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign s_axi_awready_out          = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready_out           = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid_out           = bvalid_ff;
  assign s_axi_bresp_out            = bresp_ff;
  assign s_axi_arready_out          = !rvalid_ff;
  assign s_axi_rvalid_out           = rvalid_ff;
  assign s_axi_rdata_out            = rdata_ff;
  assign s_axi_rresp_out            = rresp_ff;
  assign sample_ready_out           = (count_ff != ctb_pkg::BUF_FULL_COUNT);
  assign buffer_word_out            = head_ff;
  assign buffer_word_valid_out      = head_vld_ff;
  assign buffer_entry_count_out     = count_ff;
  assign oscillator_choice_bit_out  = osc_ff;
  assign conversion_clock_count_out = eff_clk_ff;
  assign buffer_fill_mode_out       = fill_mode_ff;
  assign output_word_layout_out     = layout_ff;

endmodule

// ==== tb/ctb_props.sv ====
// Checker for the configuration and data buffer block, bound to its top module.
`timescale 1ns/10ps
module ctb_props (
  input wire logic       core_clk_in,
  input wire logic       rstn_in,
  input wire logic       sample_strobe_in,
  input wire logic       sample_ready_out,
  input wire logic       buffer_pop_in,
  input wire logic       buffer_clear_in,
  input wire logic       buffer_word_valid_out,
  input wire logic [4:0] buffer_entry_count_out,
  input wire logic       oscillator_choice_bit_out,
  input wire logic [7:0] conversion_clock_count_out,
  input wire logic [2:0] buffer_fill_mode_out,
  input wire logic [1:0] output_word_layout_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);
  ////////////////////////////////////////////////////////////////////////////////
  a_clamp_hs: assert property (
    !oscillator_choice_bit_out |-> conversion_clock_count_out >= 8'h15)
    else $error("clock count below high-speed floor");
  a_clamp_lp: assert property (
    oscillator_choice_bit_out |-> conversion_clock_count_out >= 8'h12)
    else $error("clock count below low-power floor");
  a_reset_vals: assert property (
    $rose(rstn_in) |-> !oscillator_choice_bit_out && buffer_fill_mode_out == 3'h1
      && output_word_layout_out == 2'h0) else $error("wrong values after reset");
  a_count_max: assert property (
    buffer_entry_count_out <= 5'h10) else $error("entry count above sixteen");
  a_ready_full: assert property (
    sample_ready_out == (buffer_entry_count_out != 5'h10)) else $error("ready wrong");
  a_push_count: assert property (
    sample_strobe_in && sample_ready_out && !buffer_pop_in && !buffer_clear_in
      |=> buffer_entry_count_out == $past(buffer_entry_count_out) + 5'h01)
    else $error("push did not add one entry");
  a_clear_empty: assert property (
    buffer_clear_in |=> buffer_entry_count_out == 5'h00) else $error("clear left entries");
  a_pop_word: assert property (
    buffer_pop_in && buffer_entry_count_out != 5'h00 && !buffer_clear_in
      |=> buffer_word_valid_out) else $error("pop gave no word");
  a_word_origin: assert property (
    buffer_word_valid_out |-> $past(buffer_pop_in)) else $error("word without pop");
endmodule
bind ctb_top ctb_props u_props (
  .core_clk_in(core_clk_in), .rstn_in(rstn_in), .sample_strobe_in(sample_strobe_in),
  .sample_ready_out(sample_ready_out), .buffer_pop_in(buffer_pop_in),
  .buffer_clear_in(buffer_clear_in), .buffer_word_valid_out(buffer_word_valid_out),
  .buffer_entry_count_out(buffer_entry_count_out),
  .oscillator_choice_bit_out(oscillator_choice_bit_out),
  .conversion_clock_count_out(conversion_clock_count_out),
  .buffer_fill_mode_out(buffer_fill_mode_out), .output_word_layout_out(output_word_layout_out));

// ==== tb/testbench.sv ====
// Self-checking testbench for the configuration and data buffer block.
`timescale 1ns/10ps
module testbench;
  logic        clk = 1'b0, rstn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, stb = 1'b0, ch = 1'b0, wv = 1'b0;
  logic        pop = 1'b0, clr = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ccnt;
  logic [31:0] wdata = 32'h0, rdata;
  logic [11:0] res = 12'h000;
  logic        awready, wready, bvalid, arready, rvalid, srdy, wval, osc;
  logic [1:0]  bresp, rresp, layout;
  logic [15:0] word;
  logic [4:0]  cnt;
  logic [2:0]  fmode;
  int          n_fail = 0, check_count = 0;
  logic [3:0]  strb = 4'hf;
  logic [7:0]  cw[8] = '{8'h00, 8'h14, 8'h15, 8'h16, 8'hff, 8'h00, 8'h12, 8'h13};
  logic        co[8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};
  logic [7:0]  ce[8] = '{8'h15, 8'h15, 8'h15, 8'h16, 8'hff, 8'h12, 8'h12, 8'h13};
  logic [2:0]  fm[4] = '{3'h0, 3'h1, 3'h4, 3'h6};
  logic [1:0]  ok = ctb_pkg::RESP_OKAY;
  always #25 clk = ~clk;
  ctb_top DUT (.core_clk_in(clk), .rstn_in(rstn), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(strb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .sample_strobe_in(stb), .sample_result_in(res),
    .sample_channel_in(ch), .sample_word_valid_in(wv), .sample_ready_out(srdy),
    .buffer_pop_in(pop), .buffer_clear_in(clr), .buffer_word_out(word),
    .buffer_word_valid_out(wval), .buffer_entry_count_out(cnt),
    .oscillator_choice_bit_out(osc), .conversion_clock_count_out(ccnt),
    .buffer_fill_mode_out(fmode), .output_word_layout_out(layout));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
      n_fail++;
    end
  endtask
  task automatic hang;
    $display("unexpected at %0t: expected %h got %h (no answer)", $time, 1'b1, 1'b0);
    n_fail++;
    wrap_up;
  endtask
  // Byte address of a register index; bits 1:0 stay zero.
  function automatic logic [7:0] ba(input logic [7:0] idx);
    ba = {idx[5:0], 2'b00};
  endfunction
  task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic [1:0] er);
    int i;
    @(posedge clk);
    awaddr <= ba(idx); awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        bready <= 1'b0;
        chk(er, bresp);
        break;
      end
    end
    if (i == 50) hang();
  endtask
  task automatic rchk(input logic [7:0] idx, input logic [31:0] e, input logic [1:0] er);
    int i;
    @(posedge clk);
    araddr <= ba(idx); arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rready <= 1'b0;
        chk(e, rdata);
        chk(er, rresp);
        break;
      end
    end
    if (i == 50) hang();
  endtask
  task automatic push(input logic [11:0] r, input logic c, input logic v);
    @(posedge clk);
    stb <= 1'b1; res <= r; ch <= c; wv <= v;
    @(posedge clk);
    stb <= 1'b0;
  endtask
  task automatic pop_chk(input logic [15:0] e);
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    #1;
    chk(1, wval);
    chk(e, word);
  endtask
  function automatic logic [15:0] ew(input logic [1:0] l, input logic [11:0] r,
                                     input logic c, input logic v);
    case (l)
      2'h1: ew = {r, 2'b00, c, 1'b0};
      2'h2: ew = {r, 2'b00, c, v};
      default: ew = {r, 4'h0};
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rchk(ctb_pkg::IDX_OSCILLATOR_SELECT, 32'h0, ok);
    rchk(ctb_pkg::IDX_CLK_COUNT, 32'h15, ok);
    rchk(ctb_pkg::IDX_WORD_LAYOUT, 32'h0, ok);
    rchk(ctb_pkg::IDX_FILL_MODE, 32'h1, ok);
    rchk(ctb_pkg::IDX_BUF_STATUS, 32'h0, ok);
    $display("reset values test done");
    wr(ctb_pkg::IDX_OSCILLATOR_SELECT, 32'hff, ok);
    rchk(ctb_pkg::IDX_OSCILLATOR_SELECT, 32'h1, ok);
    chk(1, osc);
    for (int k = 0; k < 8; k++) begin
      wr(ctb_pkg::IDX_OSCILLATOR_SELECT, {31'h0, co[k]}, ok);
      wr(ctb_pkg::IDX_CLK_COUNT, {24'h0, cw[k]}, ok);
      rchk(ctb_pkg::IDX_CLK_COUNT, {24'h0, ce[k]}, ok);
      chk({24'h0, ce[k]}, {24'h0, ccnt});
    end
    // The raw count is kept, so a later oscillator change must re-clamp it.
    wr(ctb_pkg::IDX_OSCILLATOR_SELECT, 32'h0, ok);
    rchk(ctb_pkg::IDX_CLK_COUNT, 32'h15, ok);
    $display("clock count test done");
    for (int k = 0; k < 4; k++) begin
      wr(ctb_pkg::IDX_FILL_MODE, {29'h0, fm[k]}, ok);
      rchk(ctb_pkg::IDX_FILL_MODE, {29'h0, fm[k]}, ok);
      chk({29'h0, fm[k]}, {29'h0, fmode});
    end
    wr(ctb_pkg::IDX_FILL_MODE, 32'hfe, ok);
    rchk(ctb_pkg::IDX_FILL_MODE, 32'h6, ok);
    // A write whose low byte lane is off must leave the mode untouched.
    strb <= 4'h0;
    wr(ctb_pkg::IDX_FILL_MODE, 32'h0, ok);
    strb <= 4'hf;
    rchk(ctb_pkg::IDX_FILL_MODE, 32'h6, ok);
    wr(8'h3f, 32'h5a, ctb_pkg::RESP_SLVERR);
    rchk(8'h3f, 32'h0, ctb_pkg::RESP_SLVERR);
    $display("fill mode and map test done");
    for (int l = 0; l < 4; l++) begin
      wr(ctb_pkg::IDX_WORD_LAYOUT, 32'hfc | l, ok);
      rchk(ctb_pkg::IDX_WORD_LAYOUT, l, ok);
      chk(l, {30'h0, layout});
      push(12'ha5c, 1'b1, 1'b1);
      push(12'h3b7, 1'b0, 1'b0);
      pop_chk(ew(2'(l), 12'ha5c, 1'b1, 1'b1));
      pop_chk(ew(2'(l), 12'h3b7, 1'b0, 1'b0));
    end
    $display("word layout test done");
    for (int k = 0; k < 17; k++) push(12'(k + 1), 1'b0, 1'b0);
    #1;
    chk(32'h10, {27'h0, cnt});
    chk(0, srdy);
    rchk(ctb_pkg::IDX_BUF_STATUS, 32'h10, ok);
    for (int k = 0; k < 16; k++) pop_chk({12'(k + 1), 4'h0});
    chk(0, cnt);
    chk(1, srdy);
    push(12'h111, 1'b0, 1'b0);
    #1;
    chk(1, cnt);
    @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    #1;
    chk(0, cnt);
    $display("buffer depth test done");
    wrap_up;
  end
endmodule
